// [shared/adcc_consts.vh]
`ifndef ADCC_CONSTS_VH
`define ADCC_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ADCC_OFS_CTRL0   8'h00
`define ADCC_OFS_CTRL1   8'h04
`define ADCC_OFS_RESULT  8'h08
`define ADCC_OFS_STATUS  8'h0C
`define ADCC_OFS_MASK    8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADCC_C0_EN       0
`define ADCC_C0_GO       1
`define ADCC_C0_CH_LO    2
`define ADCC_C0_CH_HI    5
`define ADCC_C1_REF_LO   0
`define ADCC_C1_REF_HI   1
`define ADCC_C1_CS_LO    4
`define ADCC_C1_CS_HI    6
`define ADCC_ST_DONE     0

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define ADCC_RST_CH      4'h0
`define ADCC_RST_REF     2'h0
`define ADCC_RST_CS      3'h0
`define ADCC_RST_RES     8'h00
`define ADCC_CS_RC       2'h3
`define ADCC_MSB_IDX     3'h7
`define ADCC_LSB_IDX     3'h0
`define ADCC_BIT_ONE     8'h01

`endif

// [hdl/adcc_sync.v]
`timescale 1ns/1ps
// ----------------------------------------
// Two-stage synchroniser
// ----------------------------------------
module adcc_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rstn,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // adcc_sync

// [hdl/adcc_tad_gen.v]
`timescale 1ns/1ps
`include "adcc_consts.vh"
// ----------------------------------------
// Bit period tick generator
// ----------------------------------------
module adcc_tad_gen #(
  parameter CW = 6
) (
  input  wire       clk,
  input  wire       rstn,
  input  wire       run,
  input  wire [2:0] sel,
  input  wire       rc_rise,
  output reg        tick
);

  reg  [CW-1:0] cnt;
  wire [2:0]    expo;
  wire [CW:0]   div;
  wire          is_rc;

  // Code order 000,100,001,101,010,110 gives /2../64
  assign expo  = {sel[1:0], sel[2]} + 3'h1;
  assign div   = {{CW{1'b0}}, 1'b1} << expo;
  assign is_rc = (sel[1:0] == `ADCC_CS_RC);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt  <= {CW{1'b0}};
      tick <= 1'b0;
    end else if (!run) begin
      cnt  <= {CW{1'b0}};
      tick <= 1'b0;
    end else if (is_rc) begin
      cnt  <= {CW{1'b0}};
      tick <= rc_rise;
    end else if ({1'b0, cnt} == div - 1'b1) begin
      cnt  <= {CW{1'b0}};
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end

endmodule // adcc_tad_gen

// [hdl/adcc_top.v]
`timescale 1ns/1ps
`include "adcc_consts.vh"
// Notes on behaviour
// - Result is 8 bits by successive approximation, stored in result register
// - One channel chosen by channel field feeds the single sample-and-hold
// - Reference field picks supply, external or fixed; negative is ground
// - Clock codes 000/100/001/101/010/110 divide by 2..64; x11 is RC
// - One bit per bit period; a conversion takes ten bit periods
// - Completion raises an interrupt able to wake from sleep
// - Divided clocks follow system clock; RC clock runs on its own
// - Writing go while enable is already set starts; go reads one while busy
// - On completion clear go, set done flag, load result
// - Clearing go mid-way stores partial result, rest copy last bit
// - Sleep with divided clock aborts and powers down, enable kept
module adcc_top (
  input  wire        clk,
  input  wire        rstn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        cmp_in,
  input  wire        rc_clk_in,
  input  wire        sleep_in,
  output reg  [3:0]  chan_sel,
  output reg  [1:0]  ref_sel,
  output reg  [7:0]  dac_code,
  output reg         hold,
  output reg         adc_power,
  output reg         irq
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_HOLD = 4'b0010;
  localparam [3:0] S_BITS = 4'b0100;
  localparam [3:0] S_FIN  = 4'b1000;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg  [3:0] state;
  reg  [3:0] next_state;
  reg        enable;
  reg  [2:0] clk_sel;
  reg  [7:0] result;
  reg        done_flag;
  reg        done_mask;
  reg  [7:0] sar;
  reg  [2:0] bit_idx;
  reg        rc_prev;
  reg  [7:0] partial;
  reg        last_bit;
  reg  [31:0] next_rdata;
  reg        next_err;
  wire [2:0] sync_q;
  wire       cmp_s;
  wire       rc_s;
  wire       sleep_s;
  wire       rc_rise;
  wire       tick;
  wire       is_rc;
  wire       busy;
  wire       setup;
  wire       wr;
  wire       hit_c0;
  wire       hit_c1;
  wire       hit_res;
  wire       hit_st;
  wire       hit_mk;
  wire       go_set;
  wire       go_clr;
  wire       slp_abort;
  wire       finish;
  integer    i;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  adcc_sync #(
    .W (3)
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({sleep_in, rc_clk_in, cmp_in}),
    .q    (sync_q)
  );

  assign cmp_s   = sync_q[0];
  assign rc_s    = sync_q[1];
  assign sleep_s = sync_q[2];

  // RC edge seen only after two flops
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rc_prev <= 1'b0;
    end else begin
      rc_prev <= rc_s;
    end
  end

  assign rc_rise = rc_s & ~rc_prev;

  // ----------------------------------------
  // Bit period generator
  // ----------------------------------------
  adcc_tad_gen #(
    .CW (6)
  ) u_tad (
    .clk     (clk),
    .rstn    (rstn),
    .run     (busy),
    .sel     (clk_sel),
    .rc_rise (rc_rise),
    .tick    (tick)
  );

  assign is_rc = (clk_sel[1:0] == `ADCC_CS_RC);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign setup   = psel & ~penable;
  assign wr      = psel & penable & pwrite & pready;
  assign hit_c0  = (paddr == `ADCC_OFS_CTRL0);
  assign hit_c1  = (paddr == `ADCC_OFS_CTRL1);
  assign hit_res = (paddr == `ADCC_OFS_RESULT);
  assign hit_st  = (paddr == `ADCC_OFS_STATUS);
  assign hit_mk  = (paddr == `ADCC_OFS_MASK);

  assign busy    = ~state[0];
  assign go_set  = wr & hit_c0 & pwdata[`ADCC_C0_GO]
                   & enable & ~busy;
  assign go_clr  = wr & hit_c0 & ~pwdata[`ADCC_C0_GO]
                   & busy;
  assign slp_abort = sleep_s & ~is_rc & busy;
  assign finish  = state[3] & tick;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always @* begin
    next_rdata = 32'h00000000;
    next_err   = 1'b0;
    if (hit_c0) begin
      next_rdata[`ADCC_C0_EN] = enable;
      next_rdata[`ADCC_C0_GO] = busy;
      next_rdata[`ADCC_C0_CH_HI:`ADCC_C0_CH_LO] = chan_sel;
    end else if (hit_c1) begin
      next_rdata[`ADCC_C1_REF_HI:`ADCC_C1_REF_LO] = ref_sel;
      next_rdata[`ADCC_C1_CS_HI:`ADCC_C1_CS_LO] = clk_sel;
    end else if (hit_res) begin
      next_rdata[7:0] = result;
    end else if (hit_st) begin
      next_rdata[`ADCC_ST_DONE] = done_flag;
    end else if (hit_mk) begin
      next_rdata[`ADCC_ST_DONE] = done_mask;
    end else begin
      next_err = 1'b1;
    end
  end

  // One wait-free access phase
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup & next_err;
      if (setup && !pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enable    <= 1'b0;
      chan_sel  <= `ADCC_RST_CH;
      ref_sel   <= `ADCC_RST_REF;
      clk_sel   <= `ADCC_RST_CS;
      done_mask <= 1'b0;
    end else if (wr) begin
      if (hit_c0) begin
        enable   <= pwdata[`ADCC_C0_EN];
        chan_sel <= pwdata[`ADCC_C0_CH_HI:`ADCC_C0_CH_LO];
      end
      if (hit_c1) begin
        ref_sel <= pwdata[`ADCC_C1_REF_HI:`ADCC_C1_REF_LO];
        clk_sel <= pwdata[`ADCC_C1_CS_HI:`ADCC_C1_CS_LO];
      end
      if (hit_mk) begin
        done_mask <= pwdata[`ADCC_ST_DONE];
      end
    end
  end

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (go_set) begin
          next_state = S_HOLD;
        end
      end
      S_HOLD: begin
        if (go_clr || slp_abort || !enable) begin
          next_state = S_IDLE;
        end else if (tick) begin
          next_state = S_BITS;
        end
      end
      S_BITS: begin
        if (go_clr || slp_abort || !enable) begin
          next_state = S_IDLE;
        end else if (tick && bit_idx == `ADCC_LSB_IDX) begin
          next_state = S_FIN;
        end
      end
      S_FIN: begin
        if (go_clr || slp_abort || !enable) begin
          next_state = S_IDLE;
        end else if (tick) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Approximation register
  // ----------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sar     <= `ADCC_RST_RES;
      bit_idx <= `ADCC_MSB_IDX;
    end else if (go_set) begin
      sar     <= `ADCC_BIT_ONE << `ADCC_MSB_IDX;
      bit_idx <= `ADCC_MSB_IDX;
    end else if (state[2] && tick) begin
      sar[bit_idx] <= cmp_s;
      if (bit_idx != `ADCC_LSB_IDX) begin
        sar[bit_idx - 3'h1] <= 1'b1;
        bit_idx <= bit_idx - 3'h1;
      end
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dac_code <= `ADCC_RST_RES;
      hold     <= 1'b0;
    end else begin
      dac_code <= sar;
      hold     <= ~next_state[0];
    end
  end

  // ----------------------------------------
  // Partial result on early stop
  // ----------------------------------------
  always @* begin
    partial  = sar;
    last_bit = 1'b0;
    if (state[2] && bit_idx != `ADCC_MSB_IDX) begin
      last_bit = sar[bit_idx + 3'h1];
    end
    if (state[3]) begin
      partial = sar;
    end else begin
      for (i = 0; i < 8; i = i + 1) begin
        if (!state[2] || i <= bit_idx) begin
          partial[i] = last_bit;
        end
      end
    end
  end

  // ----------------------------------------
  // Result register
  // ----------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      result <= `ADCC_RST_RES;
    end else if (finish && !go_clr && !slp_abort) begin
      result <= sar;
    end else if (go_clr) begin
      result <= partial;
    end else if (wr && hit_res && !busy) begin
      result <= pwdata[7:0];
    end
  end

  // ----------------------------------------
  // Done flag and interrupt
  // ----------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      done_flag <= 1'b0;
    end else if (finish && !go_clr && !slp_abort) begin
      done_flag <= 1'b1;
    end else if (wr && hit_st && pwdata[`ADCC_ST_DONE]) begin
      done_flag <= 1'b0;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= done_flag & done_mask;
    end
  end

  // ----------------------------------------
  // Converter power
  // ----------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      adc_power <= 1'b0;
    end else begin
      adc_power <= enable & ~(sleep_s & ~(is_rc & busy));
    end
  end

endmodule // adcc_top

// [verification/adcc_assertions.sv]
`timescale 1ns/1ps
// --------------------
// Port checker
// --------------------
module adcc_chk (
  input wire        clk,
  input wire        rstn,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  input wire        hold,
  input wire        adc_power,
  input wire [7:0]  dac_code,
  input wire        sleep_in,
  input wire        irq
);
  reg [9:0] hcnt;

  // Length of the current hold span
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      hcnt <= 10'h000;
    else
      hcnt <= hold ? hcnt + 10'h001 : 10'h000;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error alone");
  property p_pwr; hold |-> adc_power; endproperty
  a_pwr: assert property (p_pwr) else $error("unpowered");
  property p_slp; (sleep_in && !hold)[*4] |-> !adc_power; endproperty
  a_slp: assert property (p_slp) else $error("sleep power");
  property p_msb; $rose(hold) |-> ##[1:200] dac_code == 8'h80; endproperty
  a_msb: assert property (p_msb) else $error("no msb trial");
  property p_min; $rose(hold) |-> hold[*8]; endproperty
  a_min: assert property (p_min) else $error("hold short");
  property p_max; hcnt <= 10'h2BC; endproperty
  a_max: assert property (p_max) else $error("hold long");
  property p_irq; $rose(irq) |-> !hold; endproperty
  a_irq: assert property (p_irq) else $error("irq early");
endmodule // adcc_chk

// [verification/adcc_ana_model.sv]
`timescale 1ns/1ps
// --------------------
// Channel mux and comparator
// --------------------
module adcc_ana_model (
  input  wire [3:0] chan_sel,
  input  wire [7:0] dac_code,
  input  wire       adc_power,
  output wire       cmp_in
);
  wire [7:0] level;

  assign level  = {chan_sel, chan_sel} ^ 8'h5A;
  assign cmp_in = adc_power ? (level >= dac_code) : ~dac_code[0];
endmodule // adcc_ana_model

// [verification/sar_adc_conversion_control_tb_top.sv]
`timescale 1ns/1ps
`include "adcc_consts.vh"
module sar_adc_conversion_control_tb_top;
  reg         clk = 1'b0;
  reg         rstn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0;
  reg  [31:0] rd;
  reg         er;
  reg         rc_clk_in = 1'b0;
  reg         sleep_in = 1'b0;
  reg         hold_q = 1'b0;
  reg  [9:0]  hlen = 10'h0;
  int         errors = 0;
  int         total_checks = 0;
  wire [31:0] prdata;
  wire        pready, pslverr, cmp_in, hold, adc_power, irq;
  wire [3:0]  chan_sel;
  wire [1:0]  ref_sel;
  wire [7:0]  dac_code;

  // --------------------
  // Clocks, design, model
  // --------------------
  initial forever #4 clk = ~clk;
  initial forever #22 rc_clk_in = ~rc_clk_in;

  always @(posedge clk) begin
    hold_q <= hold;
    hlen <= hold ? (hold_q ? hlen + 10'h1 : 10'h1) : hlen;
  end

  adcc_top i_adcc_top (.clk, .rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cmp_in, .rc_clk_in, .sleep_in,
    .chan_sel, .ref_sel, .dac_code, .hold, .adc_power, .irq);
  adcc_ana_model i_adcc_ana_model (.chan_sel, .dac_code, .adc_power,
    .cmp_in);

  // --------------------
  // Tasks
  // --------------------
  function [7:0] lvl(input [3:0] c);
    lvl = {c, c} ^ 8'h5A;
  endfunction

  task chk(input string n, input [31:0] e, input [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask

  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input [7:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input string s, input [7:0] a, input [31:0] m, input [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(s, e, rd & m);
  endtask

  task wait_go;
    int n;
    n = 0;
    do begin
      apb(1'b0, `ADCC_OFS_CTRL0, 32'h0);
      n++;
    end while (rd[1] !== 1'b0 && n < 400);
    chk("go_clear", 32'h0, {31'h0, rd[1]});
  endtask

  task start(input [2:0] cs, input [3:0] ch);
    wr(`ADCC_OFS_CTRL1, {25'h0, cs, 4'h0});
    wr(`ADCC_OFS_CTRL0, {26'h0, ch, 2'h1});
    repeat (20) @(posedge clk);
    wr(`ADCC_OFS_CTRL0, {26'h0, ch, 2'h3});
  endtask

  task conv(input [2:0] cs, input [3:0] ch, input sl);
    start(cs, ch);
    sleep_in <= sl;
    wait_go();
  endtask

  // --------------------
  // Scenarios
  // --------------------
  task t_regs;
    rdc("ctrl0", `ADCC_OFS_CTRL0, 32'hFF, 32'h0);
    rdc("ctrl1", `ADCC_OFS_CTRL1, 32'hFF, 32'h0);
    rdc("result", `ADCC_OFS_RESULT, 32'hFF, 32'h0);
    for (int i = 1; i < 4; i++) begin
      wr(`ADCC_OFS_CTRL1, i);
      rdc("ref", `ADCC_OFS_CTRL1, 32'h3, i);
      chk("ref_pin", i, ref_sel);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, er);
    wr(`ADCC_OFS_CTRL0, 32'h3);
    rdc("go_refused", `ADCC_OFS_CTRL0, 32'h3, 32'h1);
    $display("regs test done");
  endtask

  task t_conv;
    bit [2:0] cs_t [7] = '{3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    int dv_t [7] = '{4, 8, 16, 32, 64, 0, 0}; // no divide by 2
    int lo, hi;
    for (int i = 0; i < 7; i++) begin
      conv(cs_t[i], i + 1, i >= 5);
      sleep_in <= 1'b0;
      rdc("res", `ADCC_OFS_RESULT, 32'hFF, lvl(i + 1));
      chk("chan", i + 1, chan_sel);
      lo = dv_t[i] ? 10 * dv_t[i] - 2 : 45;
      hi = dv_t[i] ? 10 * dv_t[i] + 6 : 85;
      chk("hold_len", 32'h1, hlen >= lo && hlen <= hi);
      rdc("done", `ADCC_OFS_STATUS, 32'h1, 32'h1);
      wr(`ADCC_OFS_STATUS, 32'h1);
      rdc("done_clr", `ADCC_OFS_STATUS, 32'h1, 32'h0);
    end
    $display("conversion test done");
  endtask

  task t_irq;
    wr(`ADCC_OFS_MASK, 32'h1);
    conv(3'h4, 4'h2, 1'b0);
    chk("irq_on", 32'h1, irq);
    wr(`ADCC_OFS_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_off", 32'h0, irq);
    wr(`ADCC_OFS_MASK, 32'h0);
    conv(3'h4, 4'h3, 1'b0);
    chk("irq_mask", 32'h0, irq);
    rdc("done_unmask", `ADCC_OFS_STATUS, 32'h1, 32'h1);
    wr(`ADCC_OFS_STATUS, 32'h1);
    $display("interrupt test done");
  endtask

  task t_abort;
    start(3'h6, 4'h9);
    repeat (150) @(posedge clk);
    rdc("res_kept", `ADCC_OFS_RESULT, 32'hFF, lvl(3));
    rdc("go_on", `ADCC_OFS_CTRL0, 32'h2, 32'h2);
    repeat (195) @(posedge clk);
    wr(`ADCC_OFS_CTRL0, 32'h25);
    repeat (4) @(posedge clk);
    rdc("partial", `ADCC_OFS_RESULT, 32'hFF, 32'hC0);
    rdc("go_off", `ADCC_OFS_CTRL0, 32'h2, 32'h0);
    $display("abort test done");
  endtask

  task t_sleep;
    start(3'h6, 4'h6);
    repeat (100) @(posedge clk);
    sleep_in <= 1'b1;
    repeat (8) @(posedge clk);
    chk("hold_slp", 32'h0, hold);
    chk("pwr_slp", 32'h0, adc_power);
    rdc("en_kept", `ADCC_OFS_CTRL0, 32'h1, 32'h1);
    rdc("res_slp", `ADCC_OFS_RESULT, 32'hFF, 32'hC0);
    rdc("no_done", `ADCC_OFS_STATUS, 32'h1, 32'h0);
    sleep_in <= 1'b0;
    conv(3'h3, 4'h7, 1'b1);
    rdc("res_rc", `ADCC_OFS_RESULT, 32'hFF, lvl(7));
    rdc("done_rc", `ADCC_OFS_STATUS, 32'h1, 32'h1);
    sleep_in <= 1'b0;
    wr(`ADCC_OFS_STATUS, 32'h1);
    $display("sleep test done");
  endtask

  task final_report;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_conv();
    t_irq();
    t_abort();
    t_sleep();
    final_report();
  end

  initial begin
    #480000;
    errors++;
    final_report();
  end
endmodule // sar_adc_conversion_control_tb_top

bind adcc_top adcc_chk i_adcc_chk (.clk, .rstn, .psel, .penable, .pready,
  .pslverr, .hold, .adc_power, .dac_code, .sleep_in, .irq);
